/* bench/block_move_sequencer_tb_top.sv */
`include "block_move_defines.svh"

module block_move_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, start = 0, word_mode = 0, dma_req = 0, irq_req = 0;
  logic nmi_req = 0, sp_load = 0, stack_req = 0, stack_long = 0, slow = 0, rnd_on = 0;
  logic [`CNT_W-1:0] count_in = 16'h0000, cnt_r;
  logic [`ADDR_W-1:0] src_in = 24'h000000, dst_in = 24'h000000, sp_in = 24'h000000;
  logic [`ADDR_W-1:0] src_r, dst_r, mem_addr_r, sp_r, es, ws, ed;
  logic [`DATA_W-1:0] mem_wdata_r, mem_rdata;
  logic busy_r, done_r, mem_rd_r, mem_wr_r, mem_ack, dma_grant_r, irq_take_r;
  logic nmi_take_r, stack_acc_r;
  logic [`SIZE_W-1:0] stack_size_r;
  logic [15:0] lf = 16'h0009;
  logic [`DATA_W-1:0] rq[$];
  int err_total = 0, comparisons = 0, cyc = 0, wcnt = 0, gcnt = 0, ntk = 0, itk = 0;

  block_move_sequencer i_dut (.clk, .rstn, .start, .word_mode, .count_in, .src_in,
    .dst_in, .busy_r, .done_r, .src_r, .dst_r, .cnt_r, .mem_rd_r, .mem_wr_r,
    .mem_addr_r, .mem_wdata_r, .mem_rdata, .mem_ack, .dma_req, .dma_grant_r,
    .irq_req, .nmi_req, .irq_take_r, .nmi_take_r, .sp_load, .sp_in, .stack_req,
    .stack_long, .stack_acc_r, .stack_size_r, .sp_r);
  mem_partner i_mem (.clk, .slow, .mem_rd_r, .mem_wr_r, .mem_addr_r, .mem_ack,
    .mem_rdata);

  always #50 clk = ~clk;

  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task summarize;
    if (err_total == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task tick;
    @(posedge clk);
    #1;
  endtask

  task move(input logic wm, input logic [15:0] n, input logic [23:0] s, d,
            input int nmi_at, input logic [15:0] e);
    int k;
    es = s;
    ws = s;
    ed = d;
    wcnt = 0;
    rq.delete();
    word_mode = wm;
    count_in = n;
    src_in = s;
    dst_in = d;
    start = 1;
    tick;
    start = 0;
    for (k = 0; k < 20000 && done_r !== 1'h1; k++) begin
      nmi_req = (wcnt == nmi_at);
      tick;
    end
    nmi_req = 0;
    chk("writes", e, wcnt);
    chk("cnt", (wm ? n : {8'h00, n[7:0]}) - e, cnt_r);
    chk("src", s + e, src_r);
    chk("dst", d + e, dst_r);
  endtask

  // Bench model: reads walk the source, writes replay the source bytes at dest
  always @(negedge clk) if (rstn) begin
    if (mem_ack && mem_rd_r) begin
      chk("rd_addr", es, mem_addr_r);
      rq.push_back(mem_rdata);
      es++;
    end
    if (mem_ack && mem_wr_r) begin
      chk("wr_addr", ed, mem_addr_r);
      chk("wr_data", ws[7:0] ^ 8'h5A, mem_wdata_r);
      chk("wr_fifo", (rq.size() != 0) ? rq.pop_front() : 32'h00000100, mem_wdata_r);
      ed++;
      ws++;
      wcnt++;
    end
    chk("rd_and_wr", 0, mem_rd_r & mem_wr_r);
    if (dma_grant_r) begin
      gcnt++;
      chk("grant_gap", 0, mem_rd_r | mem_wr_r | !busy_r);
    end
    if (nmi_take_r | irq_take_r) chk("take_busy", 0, busy_r);
    ntk += nmi_take_r;
    itk += irq_take_r;
  end

  always @(posedge clk) begin
    #1;
    if (irq_take_r) irq_req = 0;
    if (rnd_on) begin
      lf = nxt(lf);
      dma_req = lf[0] & lf[2];
      slow = lf[4];
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      summarize;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1;
    chk("size_rst", 1, stack_size_r);
    chk("sp_rst", 24'hXXXXXX, sp_r);
    irq_req = 1;
    move(0, 16'h1203, 24'h000100, 24'h000800, 1, 3);
    repeat (6) tick;
    chk("nmi_after_b", 1, ntk);
    chk("irq_after_b", 1, itk);
    rnd_on = 1;
    move(1, 16'h0105, 24'h0010F0, 24'h002000, -1, 16'h0105);
    rnd_on = 0;
    dma_req = 0;
    slow = 0;
    chk("dma_seen", 1, gcnt > 0);
    irq_req = 1;
    move(1, 16'h000A, 24'h003000, 24'h004000, 3, 4);
    repeat (6) tick;
    chk("nmi_after_w", 2, ntk);
    chk("irq_after_w", 2, itk);
    move(1, 16'h0000, 24'h005000, 24'h006000, -1, 0);
    stack_req = 1;
    tick;
    tick;
    chk("stack_acc", 1, stack_acc_r);
    chk("size_word", 1, stack_size_r);
    stack_long = 1;
    tick;
    tick;
    chk("size_long", 2, stack_size_r);
    stack_req = 0;
    sp_load = 1;
    sp_in = 24'h00FFFE;
    tick;
    sp_load = 0;
    tick;
    chk("sp", 24'h00FFFE, sp_r);
    summarize;
  end
endmodule

/* bench/mem_partner.sv */
`include "block_move_defines.svh"

module mem_partner (
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_rd_r,
  input wire logic mem_wr_r,
  input wire logic [`ADDR_W-1:0] mem_addr_r,
  output logic mem_ack,
  output logic [`DATA_W-1:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  int w = 0;
  initial begin
    mem_ack = 1'h0;
    mem_rdata = 8'h00;
  end
  // Data toggles off the ack cycle so a late sample never sees a stale byte
  always @(posedge clk) begin
    #1;
    if (!mem_ack && (mem_rd_r || mem_wr_r) && w >= (slow ? 2 : 0)) begin
      mem_ack = 1'h1;
      mem_rdata = mem_addr_r[7:0] ^ 8'h5A;
      w = 0;
    end else begin
      if (!mem_ack && (mem_rd_r || mem_wr_r)) w++;
      mem_ack = 1'h0;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule

/* logic/block_move_defines.svh */
`ifndef BLOCK_MOVE_DEFINES_SVH
`define BLOCK_MOVE_DEFINES_SVH

`define ADDR_W 24
`define DATA_W 8
`define CNT_W 16
`define BYTE_CNT_W 8
`define BUF_DEPTH 2
`define SIZE_W 2
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define ADDR_ONE 24'h000001
`define ADDR_ZERO 24'h000000
`define DATA_ZERO 8'h00

`endif

/* logic/block_move_pkg.sv */
package block_move_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_GAP,
    ST_WRITE,
    ST_DONE
  } move_state_t;
endpackage

/* logic/block_move_sequencer.sv */
// What this block does
// - Byte-count move holds all interrupts until done
// - Word-count move takes NMI after current byte
// - Word-count move holds maskable interrupts until done
// - DMA granted between read and write cycle
// - Each transfer is one byte read-write pair
// - Byte-count variant uses 8-bit count
// - Word-count variant uses 16-bit count
// - Stack accesses are word or longword only
// - Stack pointer has no reset value
`include "block_move_defines.svh"

module block_move_sequencer #(
  parameter int ADDR_W = `ADDR_W,
  parameter int DATA_W = `DATA_W,
  parameter int CNT_W = `CNT_W,
  parameter int BYTE_CNT_W = `BYTE_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic word_mode,
  input wire logic [CNT_W-1:0] count_in,
  input wire logic [ADDR_W-1:0] src_in,
  input wire logic [ADDR_W-1:0] dst_in,
  output logic busy_r,
  output logic done_r,
  output logic [ADDR_W-1:0] src_r,
  output logic [ADDR_W-1:0] dst_r,
  output logic [CNT_W-1:0] cnt_r,
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic [ADDR_W-1:0] mem_addr_r,
  output logic [DATA_W-1:0] mem_wdata_r,
  input wire logic [DATA_W-1:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic dma_req,
  output logic dma_grant_r,
  input wire logic irq_req,
  input wire logic nmi_req,
  output logic irq_take_r,
  output logic nmi_take_r,
  input wire logic sp_load,
  input wire logic [ADDR_W-1:0] sp_in,
  input wire logic stack_req,
  input wire logic stack_long,
  output logic stack_acc_r,
  output logic [`SIZE_W-1:0] stack_size_r,
  output logic [ADDR_W-1:0] sp_r
);
  block_move_pkg::move_state_t st_r, st_nxt;
  logic busy_nxt, done_nxt, rd_nxt, wr_nxt, grant_nxt, word_r, word_nxt;
  logic nmi_pend_r, nmi_pend_nxt, irq_take_nxt, nmi_take_nxt;
  logic [ADDR_W-1:0] src_nxt, dst_nxt, addr_nxt;
  logic [CNT_W-1:0] cnt_nxt;
  logic [DATA_W-1:0] wdata_nxt;

  // The byte count must leave upper count bits to clear
  initial begin
    if (BYTE_CNT_W < 1 || BYTE_CNT_W >= CNT_W) begin
      $error("byte count width must be narrower than the word count");
    end
    if (ADDR_W < 2 || DATA_W < 1) begin
      $error("address or data width too small");
    end
  end

  // Both pointers wrap alike at the top of the address space
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a);
    return a + ADDR_W'(`ADDR_ONE);
  endfunction

  byte_stream_if #(.W(DATA_W)) buf_in ();
  byte_stream_if #(.W(DATA_W)) buf_out ();

  // A stalled write side keeps the read byte here instead of losing it
  byte_buffer #(.W(DATA_W), .DEPTH(`BUF_DEPTH)) u_buf (
    .clk(clk),
    .rstn(rstn),
    .fill(buf_in),
    .drain(buf_out)
  );

  always_comb begin
    buf_in.valid = (st_r == block_move_pkg::ST_READ) && mem_rd_r && mem_ack;
    buf_in.data = mem_rdata;
    buf_out.ready = (st_r == block_move_pkg::ST_GAP) && !dma_req;
  end

  always_comb begin
    st_nxt = st_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    rd_nxt = mem_rd_r;
    wr_nxt = mem_wr_r;
    grant_nxt = 1'b0;
    word_nxt = word_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    cnt_nxt = cnt_r;
    addr_nxt = mem_addr_r;
    wdata_nxt = mem_wdata_r;
    irq_take_nxt = 1'b0;
    nmi_take_nxt = 1'b0;
    // A new NMI in the cycle it is taken stays pending
    nmi_pend_nxt = (nmi_pend_r && !nmi_take_r) || nmi_req;
    unique case (st_r)
      block_move_pkg::ST_IDLE: begin
        if (start) begin
          word_nxt = word_mode;
          src_nxt = src_in;
          dst_nxt = dst_in;
          busy_nxt = 1'b1;
          if (word_mode) begin
            cnt_nxt = count_in;
          end else begin
            cnt_nxt = {{(CNT_W-BYTE_CNT_W){1'b0}}, count_in[BYTE_CNT_W-1:0]};
          end
          // Zero count ends at once without any bus cycle
          if (cnt_nxt == CNT_W'(`CNT_ZERO)) begin
            st_nxt = block_move_pkg::ST_DONE;
          end else begin
            st_nxt = block_move_pkg::ST_READ;
          end
        end else if (nmi_pend_r && !nmi_take_r) begin
          nmi_take_nxt = 1'b1;
        end else if (irq_req && !irq_take_r) begin
          irq_take_nxt = 1'b1;
        end
      end
      block_move_pkg::ST_READ: begin
        // Read waits for room so the byte always has a place to land
        if (!mem_rd_r && buf_in.ready) begin
          rd_nxt = 1'b1;
          addr_nxt = src_r;
        end else if (mem_rd_r && mem_ack) begin
          rd_nxt = 1'b0;
          st_nxt = block_move_pkg::ST_GAP;
        end
      end
      block_move_pkg::ST_GAP: begin
        if (dma_req) begin
          grant_nxt = 1'b1;
        end else if (buf_out.valid) begin
          wdata_nxt = buf_out.data;
          addr_nxt = dst_r;
          wr_nxt = 1'b1;
          st_nxt = block_move_pkg::ST_WRITE;
        end
      end
      block_move_pkg::ST_WRITE: begin
        if (mem_ack) begin
          wr_nxt = 1'b0;
          src_nxt = step_addr(src_r);
          dst_nxt = step_addr(dst_r);
          cnt_nxt = cnt_r - CNT_W'(`CNT_ONE);
          if (cnt_nxt == CNT_W'(`CNT_ZERO)) begin
            st_nxt = block_move_pkg::ST_DONE;
          end else if (word_r && nmi_pend_nxt) begin
            // Remaining bytes are left; pointers and count show where it stopped
            st_nxt = block_move_pkg::ST_DONE;
          end else begin
            st_nxt = block_move_pkg::ST_READ;
          end
        end
      end
      block_move_pkg::ST_DONE: begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = block_move_pkg::ST_IDLE;
      end
      default: begin
        st_nxt = block_move_pkg::ST_IDLE;
        busy_nxt = 1'b0;
        rd_nxt = 1'b0;
        wr_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= block_move_pkg::ST_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      dma_grant_r <= 1'b0;
      word_r <= 1'b0;
      src_r <= ADDR_W'(`ADDR_ZERO);
      dst_r <= ADDR_W'(`ADDR_ZERO);
      cnt_r <= CNT_W'(`CNT_ZERO);
      mem_addr_r <= ADDR_W'(`ADDR_ZERO);
      mem_wdata_r <= DATA_W'(`DATA_ZERO);
      nmi_pend_r <= 1'b0;
      irq_take_r <= 1'b0;
      nmi_take_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      mem_rd_r <= rd_nxt;
      mem_wr_r <= wr_nxt;
      dma_grant_r <= grant_nxt;
      word_r <= word_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      cnt_r <= cnt_nxt;
      mem_addr_r <= addr_nxt;
      mem_wdata_r <= wdata_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      irq_take_r <= irq_take_nxt;
      nmi_take_r <= nmi_take_nxt;
    end
  end

  // Stack side: no byte size exists, the low address bit is not forced
  logic stack_acc_nxt;
  logic [`SIZE_W-1:0] stack_size_nxt;
  logic [ADDR_W-1:0] sp_nxt;

  always_comb begin
    stack_acc_nxt = stack_req;
    stack_size_nxt = stack_long ? `SIZE_LONG : `SIZE_WORD;
    sp_nxt = sp_load ? sp_in : sp_r;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_acc_r <= 1'b0;
      stack_size_r <= `SIZE_WORD;
    end else begin
      stack_acc_r <= stack_acc_nxt;
      stack_size_r <= stack_size_nxt;
    end
  end

  // Deliberately outside reset: software must load it before first use
  always_ff @(posedge clk) begin
    sp_r <= sp_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_no_irq_busy: assert property (busy_r |-> !irq_take_r)
    else $error("maskable interrupt taken during move");
  a_nmi_hold_byte: assert property (busy_r && !word_r |-> !nmi_take_r)
    else $error("NMI taken during byte-count move");
  a_nmi_stop_word: assert property (
    st_r == block_move_pkg::ST_WRITE && mem_ack && word_r && nmi_req
    |=> st_r == block_move_pkg::ST_DONE ##1 !busy_r ##1 nmi_take_r)
    else $error("NMI did not end word move after the byte");
  a_irq_wait_word: assert property (word_r && busy_r |-> !irq_take_r)
    else $error("maskable interrupt taken during word move");
  a_dma_in_gap: assert property (dma_grant_r |-> !mem_rd_r && !mem_wr_r
    && $past(st_r) == block_move_pkg::ST_GAP)
    else $error("DMA granted outside the read-write gap");
  a_write_after_read: assert property (
    st_r == block_move_pkg::ST_READ && mem_rd_r && mem_ack
    |=> st_r == block_move_pkg::ST_GAP && !mem_wr_r)
    else $error("read not followed by the gap");
  a_byte_count_max: assert property (
    busy_r && !word_r |-> cnt_r[CNT_W-1:BYTE_CNT_W] == '0)
    else $error("byte-count move count above 8 bits");
  a_word_count_load: assert property (
    start && !busy_r && word_mode |=> cnt_r == $past(count_in))
    else $error("word count not taken whole");
  a_rd_hold: assert property (mem_rd_r && !mem_ack
    |=> mem_rd_r && $stable(mem_addr_r))
    else $error("read request dropped before its acknowledge");
  a_wr_hold: assert property (mem_wr_r && !mem_ack
    |=> mem_wr_r && $stable(mem_addr_r) && $stable(mem_wdata_r))
    else $error("write request changed before its acknowledge");
  a_rd_addr_src: assert property (mem_rd_r |-> mem_addr_r == src_r)
    else $error("read address is not the source pointer");
  a_wr_addr_dst: assert property (mem_wr_r |-> mem_addr_r == dst_r)
    else $error("write address is not the destination pointer");
  a_grant_needs_req: assert property (dma_grant_r |-> $past(dma_req))
    else $error("DMA granted without a request");
  a_grant_hold: assert property (dma_grant_r && dma_req |=> dma_grant_r && !mem_wr_r)
    else $error("DMA grant lost while still requested");
  a_idle_no_bus: assert property (!busy_r |-> !mem_rd_r && !mem_wr_r)
    else $error("bus cycle outside a move");
  a_done_pulse: assert property (done_r |=> !done_r)
    else $error("done held longer than one cycle");
  a_load_ptrs: assert property (start && !busy_r
    |=> src_r == $past(src_in) && dst_r == $past(dst_in))
    else $error("pointers not loaded at start");
  a_stack_no_byte: assert property (stack_size_r != '0)
    else $error("byte-sized stack access");
  a_step_ptrs: assert property (st_r == block_move_pkg::ST_WRITE && mem_ack
    |=> cnt_r == $past(cnt_r) - 1'b1 && src_r == $past(src_r) + 1'b1)
    else $error("pointer or count step wrong");
  a_zero_count: assert property (start && !busy_r && cnt_nxt == '0
    |=> st_r == block_move_pkg::ST_DONE ##1 done_r && !mem_rd_r)
    else $error("zero count started a transfer");

  c_word_nmi_abort: cover property (word_r && busy_r && nmi_pend_r ##[1:20] done_r);
  c_dma_gap: cover property (dma_grant_r ##[1:10] mem_wr_r);
  c_buffer_stall: cover property (st_r == block_move_pkg::ST_READ && !buf_in.ready);
  c_byte_done: cover property (!word_r && done_r ##[1:3] irq_take_r);
  c_word_long: cover property (word_r && busy_r && cnt_r[CNT_W-1:BYTE_CNT_W] != '0);
endmodule

/* logic/byte_buffer.sv */
`include "block_move_defines.svh"

module byte_buffer #(
  parameter int W = `DATA_W,
  parameter int DEPTH = `BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  byte_stream_if.dst fill,
  byte_stream_if.src drain
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
      $error("byte_buffer depth must be a power of two, at least 2");
    end
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic push, pop;

  always_comb begin
    push = fill.valid && fill.ready;
    pop = drain.valid && drain.ready;
    wp_nxt = push ? wp_r + PW'(1) : wp_r;
    rp_nxt = pop ? rp_r + PW'(1) : rp_r;
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; only the occupancy count says what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= fill.data;
    end
  end

  assign fill.ready = (cnt_r != (PW+1)'(DEPTH));
  assign drain.valid = (cnt_r != '0);
  assign drain.data = mem_r[rp_r];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_buf_no_over: assert property (cnt_r <= (PW+1)'(DEPTH))
    else $error("buffer occupancy above depth");
  a_buf_count_track: assert property (push && !pop |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("buffer count did not follow a push");
endmodule

/* logic/byte_stream_if.sv */
interface byte_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
